//--- hdl/ttcr_pkg.sv
// Package of constants for the temperature trip compare register set.
package ttcr_pkg;
  // --------------------------------------------------------------------
  // Register pointers
  // --------------------------------------------------------------------
  localparam logic [3:0] PTR_UPPER    = 4'h2;
  localparam logic [3:0] PTR_LOWER    = 4'h3;
  localparam logic [3:0] PTR_CRIT     = 4'h4;
  localparam logic [3:0] PTR_READOUT  = 4'h5;
  localparam logic [3:0] PTR_MAKER    = 4'h6;
  localparam logic [3:0] PTR_PARTREV  = 4'h7;
  // --------------------------------------------------------------------
  // Field layout
  // --------------------------------------------------------------------
  localparam logic [15:0] LIMIT_WMASK   = 16'h1ffc;
  localparam logic [15:0] LIMIT_RESET   = 16'h0000;
  localparam logic [15:0] READOUT_RESET = 16'h0000;
  localparam int          CRIT_BIT      = 15;
  localparam int          ABOVE_BIT     = 14;
  localparam int          BELOW_BIT     = 13;
  localparam int          SIGN_BIT      = 12;
  // --------------------------------------------------------------------
  // Identity codes, arbitrary values
  // --------------------------------------------------------------------
  localparam logic [15:0] MAKER_CODE    = 16'h5a5a;
  localparam logic [7:0]  PART_CODE     = 8'h3c;
  localparam logic [7:0]  REV_CODE      = 8'h01;
  // --------------------------------------------------------------------
  // Bus states and device address
  // --------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK   = 3'b101,
    ST_RACK  = 3'b110,
    ST_SKIP  = 3'b111
  } ttcr_state_e;
  localparam logic [6:0]  DEV_ADDR      = 7'h18;
endpackage

//--- hdl/ttcr_compare.sv
// Signed threshold compare of a readout sample against the three limits.
`timescale 1ns/10ps
module ttcr_compare
(
  input  wire logic [15:0] sample,
  input  wire logic [15:0] upper_alarm_limit,
  input  wire logic [15:0] lower_alarm_limit,
  input  wire logic [15:0] critical_limit,
  output logic             above_critical_flag,
  output logic             above_window_flag,
  output logic             below_window_flag
);
  logic signed [12:0] t_s;
  logic signed [12:0] u_s;
  logic signed [12:0] l_s;
  logic signed [12:0] c_s;
  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  // common scale alignment
  // Both operands keep bits 12:0 at 0.0625 degree weight, so no shift needed.
  always_comb
  begin
    t_s = signed'(sample[12:0]);
    u_s = signed'(upper_alarm_limit[12:0]);
    l_s = signed'(lower_alarm_limit[12:0]);
    c_s = signed'(critical_limit[12:0]);
    above_critical_flag = (t_s >= c_s);
    above_window_flag = (t_s > u_s);
    below_window_flag = (t_s < l_s);
  end
endmodule

//--- hdl/ttcr_top.sv
// Temperature trip limits, readout and identity registers behind a two-wire slave.
`timescale 1ns/10ps
module ttcr_top
#(
  parameter logic [6:0] SLAVE_ADDR = ttcr_pkg::DEV_ADDR
)
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] conv_value,
  input  wire logic        conv_done
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_s    = scl_sync[1];
  assign sda_s    = sda_sync[1];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [15:0] upper_alarm_limit_reg;
  logic [15:0] lower_alarm_limit_reg;
  logic [15:0] critical_limit_reg;
  logic [15:0] temperature_readout;
  logic [15:0] maker_identification;
  logic [15:0] part_and_revision_code;
  logic        above_critical_flag;
  logic        above_window_flag;
  logic        below_window_flag;
  logic [15:0] sample_clean;
  assign sample_clean = {3'b000, conv_value[12:1], 1'b0};
  assign maker_identification   = ttcr_pkg::MAKER_CODE;
  assign part_and_revision_code = {ttcr_pkg::PART_CODE, ttcr_pkg::REV_CODE};
  ttcr_compare u_cmp
  (
    .sample              (sample_clean),
    .upper_alarm_limit   (upper_alarm_limit_reg),
    .lower_alarm_limit   (lower_alarm_limit_reg),
    .critical_limit      (critical_limit_reg),
    .above_critical_flag (above_critical_flag),
    .above_window_flag   (above_window_flag),
    .below_window_flag   (below_window_flag)
  );
  // ----------------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------------
  ttcr_pkg::ttcr_state_e state;
  ttcr_pkg::ttcr_state_e next_state;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [3:0]  bitcnt;
  logic [3:0]  next_bitcnt;
  logic [3:0]  ptr;
  logic [3:0]  next_ptr;
  logic        hi_byte;
  logic        next_hi_byte;
  logic [7:0]  wr_hi;
  logic [7:0]  next_wr_hi;
  logic [15:0] rd_word;
  logic [15:0] next_rd_word;
  logic        is_read;
  logic        next_is_read;
  logic        ptr_phase;
  logic        next_ptr_phase;
  logic        next_sda_out;
  logic        next_sda_oe;
  logic        wr_en;
  logic [15:0] wr_word;
  logic [15:0] rd_mux;
  always_comb
  begin
    case (ptr)
      ttcr_pkg::PTR_UPPER:   rd_mux = upper_alarm_limit_reg;
      ttcr_pkg::PTR_LOWER:   rd_mux = lower_alarm_limit_reg;
      ttcr_pkg::PTR_CRIT:    rd_mux = critical_limit_reg;
      ttcr_pkg::PTR_READOUT: rd_mux = temperature_readout;
      ttcr_pkg::PTR_MAKER:   rd_mux = maker_identification;
      ttcr_pkg::PTR_PARTREV: rd_mux = part_and_revision_code;
      default:               rd_mux = 16'h0000;
    endcase
  end
  always_comb
  begin
    next_state   = state;
    next_shreg   = shreg;
    next_bitcnt  = bitcnt;
    next_ptr     = ptr;
    next_hi_byte = hi_byte;
    next_wr_hi   = wr_hi;
    next_rd_word = rd_word;
    next_is_read = is_read;
    next_sda_out = sda_out;
    next_sda_oe  = sda_oe;
    wr_en        = 1'b0;
    wr_word      = {wr_hi, shreg};
    if (start_c)
    begin
      next_state  = ttcr_pkg::ST_ADDR;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_state  = ttcr_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        ttcr_pkg::ST_IDLE:
          next_sda_oe = 1'b0;
        ttcr_pkg::ST_ADDR, ttcr_pkg::ST_PTR, ttcr_pkg::ST_WDATA:
          if (scl_rise)
          begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == 4'h8)
          begin
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b1;
            next_sda_out = 1'b0;
            next_state  = ttcr_pkg::ST_ACK;
            if (state == ttcr_pkg::ST_ADDR)
            begin
              next_is_read = shreg[0];
              next_hi_byte = 1'b1;
              next_rd_word = rd_mux;
              if (shreg[7:1] != SLAVE_ADDR)
              begin
                next_sda_oe = 1'b0;
                next_state  = ttcr_pkg::ST_SKIP;
              end
            end
            else if (state == ttcr_pkg::ST_PTR)
            begin
              next_ptr     = shreg[3:0];
              next_hi_byte = 1'b1;
              next_is_read = 1'b0;
            end
            else if (hi_byte)
            begin
              next_wr_hi   = shreg;
              next_hi_byte = 1'b0;
            end
            else
            begin
              wr_en        = 1'b1;
              next_hi_byte = 1'b1;
            end
          end
        ttcr_pkg::ST_ACK:
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            if (is_read)
            begin
              next_state   = ttcr_pkg::ST_RDATA;
              next_sda_oe  = 1'b1;
              next_sda_out = rd_word[15];
              next_rd_word = {rd_word[14:0], 1'b0};
              next_bitcnt  = 4'h1;
            end
            else if (ptr_phase)
              next_state = ttcr_pkg::ST_PTR;
            else
              next_state = ttcr_pkg::ST_WDATA;
          end
        ttcr_pkg::ST_RDATA:
          if (scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              next_sda_oe = 1'b0;
              next_state  = ttcr_pkg::ST_RACK;
            end
            else
            begin
              next_sda_out = rd_word[15];
              next_rd_word = {rd_word[14:0], 1'b0};
              next_bitcnt  = bitcnt + 4'h1;
            end
          end
        ttcr_pkg::ST_RACK:
          if (scl_rise)
          begin
            if (sda_s)
              next_state = ttcr_pkg::ST_SKIP;
            else
            begin
              next_bitcnt = 4'h0;
              next_state  = ttcr_pkg::ST_ACK;
            end
          end
        ttcr_pkg::ST_SKIP:
          next_sda_oe = 1'b0;
        default:
          next_state = ttcr_pkg::ST_IDLE;
      endcase
    end
  end
  // Pointer byte follows the address byte of a write; tracked separately.
  always_comb
  begin
    next_ptr_phase = ptr_phase;
    if (start_c)
      next_ptr_phase = 1'b1;
    else if (state == ttcr_pkg::ST_ACK && scl_fall && !is_read)
      next_ptr_phase = 1'b0;
  end
  logic [15:0] next_upper;
  logic [15:0] next_lower;
  logic [15:0] next_crit;
  logic [15:0] next_readout;
  always_comb
  begin
    next_upper   = upper_alarm_limit_reg;
    next_lower   = lower_alarm_limit_reg;
    next_crit    = critical_limit_reg;
    next_readout = temperature_readout;
    if (wr_en)
    begin
      case (ptr)
        ttcr_pkg::PTR_UPPER: next_upper = wr_word & ttcr_pkg::LIMIT_WMASK;
        ttcr_pkg::PTR_LOWER: next_lower = wr_word & ttcr_pkg::LIMIT_WMASK;
        ttcr_pkg::PTR_CRIT:  next_crit  = wr_word & ttcr_pkg::LIMIT_WMASK;
        default:             next_readout = temperature_readout;
      endcase
    end
    if (conv_done)
      next_readout = {above_critical_flag, above_window_flag, below_window_flag,
                      sample_clean[12:0]};
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state                 <= ttcr_pkg::ST_IDLE;
      shreg                 <= 8'h00;
      bitcnt                <= 4'h0;
      ptr                   <= 4'h0;
      hi_byte               <= 1'b1;
      wr_hi                 <= 8'h00;
      rd_word               <= 16'h0000;
      is_read               <= 1'b0;
      sda_out               <= 1'b1;
      sda_oe                <= 1'b0;
      ptr_phase             <= 1'b0;
      upper_alarm_limit_reg <= ttcr_pkg::LIMIT_RESET;
      lower_alarm_limit_reg <= ttcr_pkg::LIMIT_RESET;
      critical_limit_reg    <= ttcr_pkg::LIMIT_RESET;
      temperature_readout   <= ttcr_pkg::READOUT_RESET;
    end
    else
    begin
      state                 <= next_state;
      shreg                 <= next_shreg;
      bitcnt                <= next_bitcnt;
      ptr                   <= next_ptr;
      hi_byte               <= next_hi_byte;
      wr_hi                 <= next_wr_hi;
      rd_word               <= next_rd_word;
      is_read               <= next_is_read;
      sda_out               <= next_sda_out;
      sda_oe                <= next_sda_oe;
      ptr_phase             <= next_ptr_phase;
      upper_alarm_limit_reg <= next_upper;
      lower_alarm_limit_reg <= next_lower;
      critical_limit_reg    <= next_crit;
      temperature_readout   <= next_readout;
    end
  end
endmodule

//--- tb/ttcr_top_properties.sv
// Checker of the serial pin behaviour of the trip register block.
`timescale 1ns/10ps
module ttcr_checker
#(
  parameter logic [6:0] SLAVE_ADDR = ttcr_pkg::DEV_ADDR
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ----
  // Bus decoder
  // ----
  logic       scl_q;
  logic       sda_q;
  logic       foreign;
  logic [3:0] bitcnt;
  logic [1:0] bytecnt;
  logic [7:0] shreg;
  logic [7:0] addr;
  wire        edge_up  = scl_in && !scl_q;
  wire        frame    = scl_in && scl_q && (sda_q != sda_in);
  wire        ack_slot = edge_up && bitcnt == 4'h8;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      foreign <= 1'b0;
      bitcnt  <= 4'h0;
      bytecnt <= 2'h0;
      shreg   <= 8'h00;
      addr    <= 8'h00;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (frame)
      begin
        bitcnt  <= 4'h0;
        bytecnt <= 2'h0;
        foreign <= 1'b0;
      end
      else if (ack_slot)
      begin
        bitcnt  <= 4'h0;
        bytecnt <= bytecnt + 2'(bytecnt != 2'h3);
        if (bytecnt == 2'h0)
        begin
          addr    <= shreg;
          foreign <= shreg[7:1] != SLAVE_ADDR;
        end
      end
      else if (edge_up)
      begin
        shreg  <= {shreg[6:0], sda_in};
        bitcnt <= bitcnt + 4'h1;
      end
    end
  // ----
  // Assertions
  // ----
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_reset_quiet_pin: assert property ($rose(rst_b) |-> !sda_oe && sda_out)
    else $error("sda driven out of reset");
  a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed while scl high");
  a_data_hold_high: assert property (sda_oe && scl_in && $past(scl_in)
    |-> $past(sda_oe) && $stable(sda_out))
    else $error("sda data moved while scl high");
  a_ack_own_addr: assert property (ack_slot && bytecnt == 2'h0 && shreg[7:1] == SLAVE_ADDR
    |-> sda_oe && !sda_out)
    else $error("own address not acknowledged");
  a_nack_foreign: assert property (ack_slot && bytecnt == 2'h0 && shreg[7:1] != SLAVE_ADDR
    |-> !sda_oe)
    else $error("foreign address acknowledged");
  a_quiet_foreign: assert property (foreign |-> !sda_oe)
    else $error("sda driven in foreign frame");
  a_ack_pointer: assert property (ack_slot && bytecnt == 2'h1 && !addr[0] && !foreign
    |-> sda_oe && !sda_out)
    else $error("pointer byte not acknowledged");
  a_read_release: assert property (ack_slot && bytecnt != 2'h0 && addr[0] |-> !sda_oe)
    else $error("sda held during host acknowledge");
endmodule

bind ttcr_top ttcr_checker #(.SLAVE_ADDR(SLAVE_ADDR)) i_ttcr_checker (.mclk(mclk),
  .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

//--- tb/ttcr_host_model.sv
// Behavioural two-wire host that runs register transfers on the serial pins.
`timescale 1ns/10ps
module ttcr_host_model
(
  output logic      scl,
  output logic      sda_host,
  input  wire logic sda_wire
);
  // Both lines rest high; the clock stands still outside frames.
  initial
  begin
    scl      = 1'b1;
    sda_host = 1'b1;
  end
  // Data moves 20 ns after scl falls, clear of the device's own turn-round.
  task automatic put_bit(input logic b, output logic seen);
    sda_host = b;
    #12 scl = 1'b1;
    #16 seen = sda_wire;
    #16 scl = 1'b0;
    #20;
  endtask
  task automatic start_cond;
    sda_host = 1'b1;
    #12 scl = 1'b1;
    #16 sda_host = 1'b0;
    #16 scl = 1'b0;
    #20;
  endtask
  task automatic stop_cond;
    sda_host = 1'b0;
    #12 scl = 1'b1;
    #16 sda_host = 1'b1;
    #32;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(last, s);
  endtask
  // No alarm output sits on this bus, so limits are rewritten directly.
  task automatic xfer_wr(input logic [6:0] a, input logic [3:0] p, input logic [15:0] d,
                         output logic ok);
    logic [3:0] k;
    start_cond();
    put_byte({a, 1'b0}, k[0]);
    put_byte({4'h0, p}, k[1]);
    put_byte(d[15:8], k[2]);
    put_byte(d[7:0], k[3]);
    stop_cond();
    ok = &k;
  endtask
  task automatic xfer_rd(input logic [6:0] a, input logic [3:0] p, output logic [15:0] d,
                         output logic ok);
    logic [2:0] k;
    start_cond();
    put_byte({a, 1'b0}, k[0]);
    put_byte({4'h0, p}, k[1]);
    start_cond();
    put_byte({a, 1'b1}, k[2]);
    get_byte(1'b0, d[15:8]);
    get_byte(1'b1, d[7:0]);
    stop_cond();
    ok = &k;
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the trip limit and readout registers.
`timescale 1ns/10ps
module tb_top;
  logic        mclk       = 1'b0;
  logic        rst_b      = 1'b0;
  logic        conv_done  = 1'b0;
  logic [15:0] conv_value = 16'h0000;
  logic        scl;
  logic        sda_host;
  logic        sda_out;
  logic        sda_oe;
  wire         sda_wire = sda_host & ~(sda_oe & ~sda_out);
  logic [15:0] m [16];
  logic [15:0] pts [11] = '{16'h0190, 16'h0192, 16'h018e, 16'h1ff0, 16'h1ff2, 16'h1fee,
                            16'h07c0, 16'h07c2, 16'h07be, 16'h0000, 16'he7d0};
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  int          seed       = 24;
  always #2 mclk = ~mclk;
  ttcr_top i_ttcr_top (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_value(conv_value), .conv_done(conv_done));
  ttcr_host_model i_ttcr_host_model (.scl(scl), .sda_host(sda_host), .sda_wire(sda_wire));
  // ----
  // Shared tasks
  // ----
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic int s13(logic [12:0] x);
    return int'($signed(x));
  endfunction
  task automatic wr(logic [3:0] p, logic [15:0] d);
    logic ok;
    i_ttcr_host_model.xfer_wr(ttcr_pkg::DEV_ADDR, p, d, ok);
    check("write ack", 16'h0001, {15'h0000, ok});
    if (p inside {[2:4]}) m[p] = d & 16'h1ffc;
  endtask
  task automatic rd(logic [3:0] p);
    logic        ok;
    logic [15:0] d;
    i_ttcr_host_model.xfer_rd(ttcr_pkg::DEV_ADDR, p, d, ok);
    check("read ack", 16'h0001, {15'h0000, ok});
    check($sformatf("register %0d", p), m[p], d);
  endtask
  // Flags are worked out against the limits live at the moment of capture.
  task automatic conv(logic [15:0] v);
    int t;
    @(negedge mclk);
    conv_value = v;
    conv_done  = 1'b1;
    @(negedge mclk);
    conv_done = 1'b0;
    t = s13({v[12:1], 1'b0});
    m[5] = {t >= s13(m[4][12:0]), t > s13(m[2][12:0]), t < s13(m[3][12:0]), v[12:1], 1'b0};
    rd(4'h5);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      mismatches++;
      test_done();
    end
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    logic ok;
    foreach (m[i]) m[i] = 16'h0000;
    m[6] = ttcr_pkg::MAKER_CODE;
    m[7] = {ttcr_pkg::PART_CODE, ttcr_pkg::REV_CODE};
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    for (int p = 2; p < 10; p++) rd(4'(p));
    $display("test reset values done");
    for (int n = 0; n < 2; n++)
      for (int p = 2; p < 10; p++)
      begin
        wr(4'(p), n == 0 ? 16'hffff : 16'($random(seed)));
        rd(4'(p));
      end
    $display("test register access done");
    i_ttcr_host_model.xfer_wr(ttcr_pkg::DEV_ADDR ^ 7'h01, 4'h2, 16'h0154, ok);
    check("foreign ack", 16'h0000, {15'h0000, ok});
    rd(4'h2);
    $display("test foreign address done");
    wr(4'h2, 16'h0190);
    wr(4'h3, 16'h1ff0);
    wr(4'h4, 16'h07c0);
    foreach (pts[i]) conv(pts[i]);
    $display("test boundary flags done");
    repeat (6)
    begin
      wr(4'(2 + ($random(seed) & 3) % 3), 16'($random(seed)));
      conv(16'($random(seed)));
    end
    $display("test limit rewrite done");
    test_done();
  end
endmodule
